// ===== css_pkg.sv
package css_pkg;
  // divisor range of the bit-rate generator
  localparam logic [7:0] DIV_MIN = 8'h00;
  localparam logic [7:0] DIV_MAX = 8'hFF;
  localparam logic [7:0] DIV_RESET = 8'h00;
  localparam int BITS_PER_BYTE = 8;
  localparam logic [3:0] BIT_COUNT_LAST = 4'h7;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam int SYNC_STAGES = 2;

  typedef enum logic [1:0] {
    CSS_IDLE,
    CSS_SHIFT,
    CSS_DONE
  } css_state_e;

  // control bits written by software
  typedef struct packed {
    logic tx_enable;
    logic rx_enable;
    logic ext_clock;
    logic clk_polarity;
    logic msb_first;
    logic hs_disable;
    logic hs_rts_select;
    logic tx_irq_on_done;
    logic cont_receive;
    logic data_invert;
    logic dual_clk_enable;
    logic alt_pin_select;
  } css_ctrl_s;

  // status shown to software
  typedef struct packed {
    logic tx_buffer_empty;
    logic rx_buffer_full;
    logic overrun;
    logic busy;
  } css_stat_s;
endpackage

// ===== css_bit_gen.sv
`timescale 1ns/1ns
// ----------------------------------------
// bit-rate generator: one tick every n+1 cycles
// ----------------------------------------
module css_bit_gen #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST_N,
  // control
  input wire logic run,
  input wire logic [WIDTH-1:0] divisor,
  // tick out
  output logic tick
);
  logic [WIDTH-1:0] count_reg;

  if (WIDTH < 1)
  begin : g_bad_width
    $error("css_bit_gen: WIDTH must be positive");
  end

  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
      count_reg <= '0;
    else if (!run || count_reg == divisor)
      count_reg <= '0;
    else
      count_reg <= count_reg + 1'b1;
  end

  assign tick = run && (count_reg == divisor);
endmodule // css_bit_gen

// ===== css_channel.sv
`timescale 1ns/1ns
// Functional notes
// - divisor n from 00 to FF sets the internal transfer clock rate
// - overrun overwrites receive buffer and leaves receive request low
// - serial output stays high after mode select until first transfer
// - reception only still shifts dummy transmit data out
// - serial input pin is data input when its direction bit is 0 (the direction bit is ignored here, input always read)
// - clock select 0 drives transfer clock out, 1 takes it in
// - handshake enabled with select 1 makes shared pin a send request output
// - handshake disable 1 frees shared pin as general-purpose port
// - polarity bit picks launch and sample edges
// - bit order 0 is LSB first, 1 is MSB first
// - second channel routes clock out to one of two pins
// - dual clock pins apply only with internal clock
// - dual clock pins disable the handshake on the second channel
// - continuous receive re-arms reception on receive buffer read
// - third channel inverts data on transmit write and receive read
// - transmit starts with enable, buffer full and clear-to-send low
// - receive starts with both enables and buffer full
// - receive request when byte moves to receive buffer
// - transmit request on buffer load or on shift done, by cause bit
module css_channel #(
  parameter bit HAS_DUAL_CLK = 1'b0,
  parameter bit HAS_INVERT = 1'b0
) (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST_N,
  // configuration
  input wire css_pkg::css_ctrl_s CTRL,
  input wire logic [7:0] DIVISOR,
  input wire logic RX_DIR_BIT,
  // transmit buffer write
  input wire logic TX_WRITE,
  input wire logic [7:0] TX_DATA,
  // receive buffer read
  input wire logic RX_READ,
  output logic [7:0] RX_DATA,
  // status and requests
  output css_pkg::css_stat_s STATUS,
  output logic TX_REQ,
  output logic RX_REQ,
  // serial pins
  output logic SERIAL_OUT_PIN,
  input wire logic SERIAL_IN_PIN,
  output logic RX_PORT_IN,
  input wire logic TRANSFER_CLOCK_PIN_I,
  output logic TRANSFER_CLOCK_PIN_O,
  output logic TRANSFER_CLOCK_PIN_OE,
  output logic ALTERNATE_CLOCK_OUT_PIN_O,
  output logic ALTERNATE_CLOCK_OUT_PIN_OE,
  // shared handshake pin and its port function
  input wire logic HS_PIN_I,
  output logic HS_PIN_O,
  output logic HS_PIN_OE,
  input wire logic GPIO_OUT,
  input wire logic GPIO_OE,
  output logic GPIO_IN
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [1:0] clk_sync_reg;
  logic [1:0] din_sync_reg;
  logic [1:0] cts_sync_reg;
  logic ext_clk_prev_reg;

  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      clk_sync_reg <= 2'h3;
      din_sync_reg <= 2'h3;
      cts_sync_reg <= 2'h3;
      ext_clk_prev_reg <= 1'b1;
    end
    else
    begin
      clk_sync_reg <= {clk_sync_reg[0], TRANSFER_CLOCK_PIN_I};
      din_sync_reg <= {din_sync_reg[0], SERIAL_IN_PIN};
      cts_sync_reg <= {cts_sync_reg[0], HS_PIN_I};
      ext_clk_prev_reg <= clk_sync_reg[1];
    end
  end

  logic din_s;
  logic cts_s;
  assign din_s = din_sync_reg[1];
  assign cts_s = cts_sync_reg[1];
  assign RX_PORT_IN = din_s; // plain port use when only transmitting
  assign GPIO_IN = cts_s;

  // ----------------------------------------
  // handshake pin mode
  // ----------------------------------------
  logic dual_active;
  logic hs_active;
  logic cts_used;
  logic rts_used;
  assign dual_active = HAS_DUAL_CLK && CTRL.dual_clk_enable && !CTRL.ext_clock;
  assign hs_active = !CTRL.hs_disable && !dual_active;
  assign cts_used = hs_active && !CTRL.hs_rts_select;
  assign rts_used = hs_active && CTRL.hs_rts_select;

  // ----------------------------------------
  // buffers and state
  // ----------------------------------------
  css_pkg::css_state_e state_reg;
  logic [7:0] tx_buf_reg;
  logic tx_full_reg;
  logic [7:0] shift_out_reg;
  logic [7:0] shift_in_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] rx_buf_reg;
  logic rx_full_reg;
  logic overrun_reg;
  logic int_clk_reg;
  logic out_reg;
  logic started_reg;
  logic rx_armed_reg;
  logic is_receiving_reg;

  // ----------------------------------------
  // transfer clock edges
  // ----------------------------------------
  logic tick;
  logic run_int;
  logic idle_level;
  logic launch_edge;
  logic sample_edge;
  logic rise;
  logic fall;

  assign run_int = (state_reg == css_pkg::CSS_SHIFT) && !CTRL.ext_clock;
  assign idle_level = !CTRL.clk_polarity;

  css_bit_gen #(.WIDTH(8)) u_bit_gen (
    .CLOCK(CLOCK),
    .RST_N(RST_N),
    .run(run_int),
    .divisor(DIVISOR),
    .tick(tick)
  );

  always_comb
  begin
    if (CTRL.ext_clock)
    begin
      rise = clk_sync_reg[1] && !ext_clk_prev_reg;
      fall = !clk_sync_reg[1] && ext_clk_prev_reg;
    end
    else
    begin
      rise = tick && !int_clk_reg;
      fall = tick && int_clk_reg;
    end
  end

  // polarity 0: launch on falling, sample on rising
  assign launch_edge = (state_reg == css_pkg::CSS_SHIFT) && (CTRL.clk_polarity ? rise : fall);
  assign sample_edge = (state_reg == css_pkg::CSS_SHIFT) && (CTRL.clk_polarity ? fall : rise);

  // external clock must rest at its idle level before a start
  logic clk_ready;
  assign clk_ready = !CTRL.ext_clock || (clk_sync_reg[1] == idle_level);

  logic start_ok;
  logic rx_gate;
  assign rx_gate = !CTRL.rx_enable || rx_armed_reg || CTRL.cont_receive;
  assign start_ok = CTRL.tx_enable && tx_full_reg && (!cts_used || !cts_s) && clk_ready
                    && rx_gate;

  logic [7:0] tx_in;
  assign tx_in = (HAS_INVERT && CTRL.data_invert) ? ~TX_DATA : TX_DATA;

  logic first_out_bit;
  assign first_out_bit = CTRL.msb_first ? tx_buf_reg[7] : tx_buf_reg[0];

  // ----------------------------------------
  // shifter state machine
  // ----------------------------------------
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      state_reg <= css_pkg::CSS_IDLE;
      shift_out_reg <= css_pkg::BYTE_RESET;
      shift_in_reg <= css_pkg::BYTE_RESET;
      bit_cnt_reg <= 4'h0;
      out_reg <= 1'b1;
      started_reg <= 1'b0;
      is_receiving_reg <= 1'b0;
    end
    else
    begin
      unique case (state_reg)
        css_pkg::CSS_IDLE:
        begin
          if (start_ok)
          begin
            state_reg <= css_pkg::CSS_SHIFT;
            // dummy data leaves too when only receiving
            shift_out_reg <= CTRL.msb_first ? {tx_buf_reg[6:0], 1'b0} : {1'b0, tx_buf_reg[7:1]};
            out_reg <= first_out_bit;
            started_reg <= 1'b1;
            bit_cnt_reg <= 4'h0;
            is_receiving_reg <= CTRL.rx_enable;
          end
        end
        css_pkg::CSS_SHIFT:
        begin
          if (sample_edge)
          begin
            // order of bits on the wire
            shift_in_reg <= CTRL.msb_first ? {shift_in_reg[6:0], din_s} : {din_s, shift_in_reg[7:1]};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            if (bit_cnt_reg == css_pkg::BIT_COUNT_LAST)
              state_reg <= css_pkg::CSS_DONE;
          end
          else if (launch_edge && bit_cnt_reg != 4'h0)
          begin
            out_reg <= CTRL.msb_first ? shift_out_reg[7] : shift_out_reg[0];
            shift_out_reg <= CTRL.msb_first ? {shift_out_reg[6:0], 1'b0} : {1'b0, shift_out_reg[7:1]};
          end
        end
        css_pkg::CSS_DONE:
          state_reg <= css_pkg::CSS_IDLE;
        default:
          state_reg <= css_pkg::CSS_IDLE;
      endcase
      if (!CTRL.tx_enable && state_reg == css_pkg::CSS_IDLE)
        started_reg <= 1'b0;
    end
  end

  // internal clock toggles at each generator tick, rests at idle level
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
      int_clk_reg <= 1'b1;
    else if (state_reg != css_pkg::CSS_SHIFT)
      int_clk_reg <= idle_level;
    else if (tick)
      int_clk_reg <= !int_clk_reg;
  end

  // ----------------------------------------
  // transmit buffer
  // ----------------------------------------
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      tx_buf_reg <= css_pkg::BYTE_RESET;
      tx_full_reg <= 1'b0;
    end
    else if (TX_WRITE)
    begin
      tx_buf_reg <= tx_in;
      tx_full_reg <= 1'b1;
    end
    // continuous receive sends the byte left in the buffer again as dummy data
    else if (CTRL.cont_receive && CTRL.rx_enable && RX_READ)
      tx_full_reg <= 1'b1;
    else if (state_reg == css_pkg::CSS_IDLE && start_ok)
      tx_full_reg <= 1'b0;
  end

  // ----------------------------------------
  // receive buffer
  // ----------------------------------------
  logic rx_load;
  assign rx_load = (state_reg == css_pkg::CSS_DONE) && is_receiving_reg;

  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      rx_buf_reg <= css_pkg::BYTE_RESET;
      rx_full_reg <= 1'b0;
      overrun_reg <= 1'b0;
    end
    else
    begin
      if (rx_load)
      begin
        rx_buf_reg <= shift_in_reg; // overwritten on overrun too
        rx_full_reg <= 1'b1;
      end
      else if (RX_READ)
        rx_full_reg <= 1'b0;
      // a clearing read in the load cycle wins over a new overrun
      if (rx_load && rx_full_reg && !RX_READ)
        overrun_reg <= 1'b1;
      else if (RX_READ || !CTRL.rx_enable)
        overrun_reg <= 1'b0;
    end
  end

  // reception arms on each dummy write, or on read in continuous mode
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
      rx_armed_reg <= 1'b0;
    else if (TX_WRITE || (CTRL.cont_receive && RX_READ))
      rx_armed_reg <= 1'b1;
    else if (state_reg == css_pkg::CSS_IDLE && start_ok)
      rx_armed_reg <= 1'b0;
  end

  assign RX_DATA = (HAS_INVERT && CTRL.data_invert) ? ~rx_buf_reg : rx_buf_reg;

  // ----------------------------------------
  // requests and status
  // ----------------------------------------
  logic tx_req_reg;
  logic rx_req_reg;
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      tx_req_reg <= 1'b0;
      rx_req_reg <= 1'b0;
    end
    else
    begin
      tx_req_reg <= CTRL.tx_irq_on_done ? (state_reg == css_pkg::CSS_DONE)
                    : (state_reg == css_pkg::CSS_IDLE && start_ok);
      rx_req_reg <= rx_load && !rx_full_reg;
    end
  end
  assign TX_REQ = tx_req_reg;
  assign RX_REQ = rx_req_reg;

  assign STATUS.tx_buffer_empty = !tx_full_reg;
  assign STATUS.rx_buffer_full = rx_full_reg;
  assign STATUS.overrun = overrun_reg;
  assign STATUS.busy = (state_reg != css_pkg::CSS_IDLE);

  // ----------------------------------------
  // pin drive
  // ----------------------------------------
  assign SERIAL_OUT_PIN = started_reg ? out_reg : 1'b1;
  // direction bit is not used: the serial input is always read
  logic unused_dir;
  assign unused_dir = RX_DIR_BIT;

  assign TRANSFER_CLOCK_PIN_OE = !CTRL.ext_clock && !(dual_active && CTRL.alt_pin_select);
  assign TRANSFER_CLOCK_PIN_O = int_clk_reg;
  assign ALTERNATE_CLOCK_OUT_PIN_OE = dual_active && CTRL.alt_pin_select;
  assign ALTERNATE_CLOCK_OUT_PIN_O = int_clk_reg;

  // send request low while ready to take a byte
  assign HS_PIN_OE = CTRL.hs_disable ? GPIO_OE : rts_used;
  assign HS_PIN_O = CTRL.hs_disable ? GPIO_OUT
                    : !(CTRL.rx_enable && !rx_full_reg && state_reg == css_pkg::CSS_IDLE);
endmodule // css_channel

// ===== css_channel_properties.sv
`timescale 1ns/1ns
// ----
// port checker
// ----
module css_chk (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST_N,
  // watched ports
  input wire css_pkg::css_ctrl_s CTRL,
  input wire css_pkg::css_stat_s STATUS,
  input wire logic TX_REQ,
  input wire logic RX_REQ,
  input wire logic SERIAL_OUT_PIN,
  input wire logic SERIAL_IN_PIN,
  input wire logic RX_PORT_IN,
  input wire logic TRANSFER_CLOCK_PIN_OE,
  input wire logic ALTERNATE_CLOCK_OUT_PIN_OE,
  input wire logic HS_PIN_O,
  input wire logic HS_PIN_OE,
  input wire logic GPIO_OUT,
  input wire logic GPIO_OE
);
  logic went_reg;
  logic [1:0] age_reg;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  always_ff @(posedge CLOCK or negedge RST_N)
    if (!RST_N)
      went_reg <= 1'b0;
    else if (STATUS.busy)
      went_reg <= 1'b1;
  // the synchroniser only mirrors the pin once it has refilled after reset
  always_ff @(posedge CLOCK or negedge RST_N)
    if (!RST_N)
      age_reg <= 2'h0;
    else if (age_reg != 2'h3)
      age_reg <= age_reg + 2'h1;
  // settings held long enough for a registered pin path to follow
  sequence s_calm;
    $stable({CTRL, GPIO_OUT, GPIO_OE})[*2];
  endsequence
  property p_idle_high;
    !went_reg && !STATUS.busy |-> SERIAL_OUT_PIN;
  endproperty
  a_idle_high: assert property (p_idle_high)
    else $error("serial out low before first transfer");
  // the clock leaves on one pin only, and only when generated inside
  property p_clk_dir;
    s_calm |-> TRANSFER_CLOCK_PIN_OE == (!CTRL.ext_clock && !ALTERNATE_CLOCK_OUT_PIN_OE);
  endproperty
  a_clk_dir: assert property (p_clk_dir)
    else $error("clock pin direction wrong");
  property p_alt_int;
    ALTERNATE_CLOCK_OUT_PIN_OE |-> !CTRL.ext_clock && CTRL.dual_clk_enable;
  endproperty
  a_alt_int: assert property (p_alt_int)
    else $error("alternate clock pin driven without internal clock");
  property p_dual_hs;
    ALTERNATE_CLOCK_OUT_PIN_OE && !CTRL.hs_disable |-> !HS_PIN_OE;
  endproperty
  a_dual_hs: assert property (p_dual_hs)
    else $error("handshake pin driven with dual clock pins");
  property p_hs_port;
    s_calm ##0 CTRL.hs_disable |-> HS_PIN_OE == GPIO_OE && HS_PIN_O == GPIO_OUT;
  endproperty
  a_hs_port: assert property (p_hs_port)
    else $error("handshake pin not a port");
  property p_rts_out;
    s_calm ##0 (!CTRL.hs_disable && CTRL.hs_rts_select && !ALTERNATE_CLOCK_OUT_PIN_OE)
      |-> HS_PIN_OE;
  endproperty
  a_rts_out: assert property (p_rts_out)
    else $error("send request not driven");
  property p_ovr_quiet;
    RX_REQ |-> !STATUS.overrun;
  endproperty
  a_ovr_quiet: assert property (p_ovr_quiet)
    else $error("receive request on overrun");
  property p_tx_early;
    $rose(STATUS.busy) && !CTRL.tx_irq_on_done |-> ##[0:2] TX_REQ;
  endproperty
  a_tx_early: assert property (p_tx_early)
    else $error("no transmit request at load");
  property p_tx_late;
    $rose(STATUS.busy) && CTRL.tx_irq_on_done |-> !TX_REQ [*4];
  endproperty
  a_tx_late: assert property (p_tx_late)
    else $error("transmit request before shift done");
  property p_port_sync;
    age_reg == 2'h3 |-> RX_PORT_IN == $past(SERIAL_IN_PIN, 2);
  endproperty
  a_port_sync: assert property (p_port_sync)
    else $error("input port does not follow pin");
  c_rx: cover property (RX_REQ);
  c_ovr: cover property ($rose(STATUS.overrun));
  c_done: cover property (TX_REQ && CTRL.tx_irq_on_done);
endmodule // css_chk
bind css_channel css_chk i_chk (
  .CLOCK(CLOCK), .RST_N(RST_N), .CTRL(CTRL), .STATUS(STATUS), .TX_REQ(TX_REQ),
  .RX_REQ(RX_REQ), .SERIAL_OUT_PIN(SERIAL_OUT_PIN), .SERIAL_IN_PIN(SERIAL_IN_PIN),
  .RX_PORT_IN(RX_PORT_IN), .TRANSFER_CLOCK_PIN_OE(TRANSFER_CLOCK_PIN_OE),
  .ALTERNATE_CLOCK_OUT_PIN_OE(ALTERNATE_CLOCK_OUT_PIN_OE),
  .HS_PIN_O(HS_PIN_O), .HS_PIN_OE(HS_PIN_OE), .GPIO_OUT(GPIO_OUT), .GPIO_OE(GPIO_OE)
);

// ===== css_peer.sv
`timescale 1ns/1ns
// ----
// far-side peer
// ----
module css_peer (
  // wire clock and data
  input wire logic clk_w,
  input wire logic so,
  output logic si,
  // format and byte
  input wire logic pol,
  input wire logic msb,
  input wire logic load,
  input wire logic [7:0] tx,
  output logic [7:0] rx
);
  int n = 8;
  logic [7:0] b;
  // lc falls on the launch edge for either polarity
  wire lc = clk_w ^ pol;
  initial si = 1'b1;
  always @(posedge load)
  begin
    b = tx;
    n = 0;
    si = msb ? tx[7] : tx[0];
  end
  always @(posedge lc)
    if (n < 8)
    begin
      rx = msb ? {rx[6:0], so} : {so, rx[7:1]};
      n++;
    end
  // inverted after the frame: no stale bit may look valid
  always @(negedge lc)
    if (n > 0 && n < 8)
      si = msb ? b[7 - n] : b[n];
    else if (n == 8)
      si = ~si;
endmodule // css_peer

// ===== css_channel_tb_top.sv
`timescale 1ns/1ns
module css_channel_tb_top;
  typedef struct packed {
    logic pol;
    logic msb;
    logic cause;
    logic [7:0] div;
    logic [7:0] t;
    logic [7:0] p;
  } css_row_s;
  // at n=0 the half period is shorter than the input sync lag: that row gets a flat byte
  css_row_s rows[4] = '{'{1'b0, 1'b0, 1'b0, 8'h00, 8'hA5, 8'hFF},
    '{1'b1, 1'b1, 1'b1, 8'h03, 8'h3C, 8'h81}, '{1'b0, 1'b1, 1'b0, 8'hFF, 8'h01, 8'h80},
    '{1'b1, 1'b0, 1'b1, 8'h05, 8'h80, 8'h01}};
  logic CLOCK = 1'b0;
  logic RST_N = 1'b0;
  css_pkg::css_ctrl_s ctrl;
  css_pkg::css_stat_s stat;
  logic [7:0] div, tx_data, rx_data, peer_tx, peer_rx;
  logic tx_wr = 1'b0, rx_rd = 1'b0, load = 1'b0, ext_clk = 1'b1, hs_drv = 1'b1;
  logic g_out = 1'b0, g_oe = 1'b0, went;
  logic tx_req, rx_req, s_out, s_in, clk_o, clk_oe, hs_o, hs_oe, g_in, alt_o, alt_oe;
  wire clk_w = clk_oe ? clk_o : ext_clk;
  wire hs_in = hs_oe ? hs_o : hs_drv;
  int fails = 0, checks = 0, nrx, tx_at, k;
  time lt = 0, per = 0;
  always #5 CLOCK = ~CLOCK;
  always @(posedge clk_o)
  begin
    per = $time - lt;
    lt = $time;
  end
  // both options built in so the dual clock pins and data inversion can be reached
  css_channel #(.HAS_DUAL_CLK(1'b1), .HAS_INVERT(1'b1)) i_dut (
    .CLOCK(CLOCK), .RST_N(RST_N), .CTRL(ctrl), .DIVISOR(div), .RX_DIR_BIT(1'b0),
    .TX_WRITE(tx_wr), .TX_DATA(tx_data), .RX_READ(rx_rd), .RX_DATA(rx_data),
    .STATUS(stat), .TX_REQ(tx_req), .RX_REQ(rx_req), .SERIAL_OUT_PIN(s_out),
    .SERIAL_IN_PIN(s_in), .RX_PORT_IN(), .TRANSFER_CLOCK_PIN_I(clk_w),
    .TRANSFER_CLOCK_PIN_O(clk_o), .TRANSFER_CLOCK_PIN_OE(clk_oe),
    .ALTERNATE_CLOCK_OUT_PIN_O(alt_o), .ALTERNATE_CLOCK_OUT_PIN_OE(alt_oe), .HS_PIN_I(hs_in),
    .HS_PIN_O(hs_o), .HS_PIN_OE(hs_oe), .GPIO_OUT(g_out), .GPIO_OE(g_oe), .GPIO_IN(g_in)
  );
  css_peer i_peer (
    .clk_w(clk_w), .so(s_out), .si(s_in), .pol(ctrl.clk_polarity),
    .msb(ctrl.msb_first), .load(load), .tx(peer_tx), .rx(peer_rx)
  );
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    if (fails == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic send(input logic [7:0] t, input logic [7:0] p);
    peer_tx = p;
    tx_data = t;
    load = 1'b1;
    tx_wr = 1'b1;
    @(negedge CLOCK);
    load = 1'b0;
    tx_wr = 1'b0;
    // the master holds off so the idle level is seen through the synchronisers
    if (ctrl.ext_clock)
      fork
        begin
          // offset keeps every wire clock edge off the rising CLOCK edge
          #52;
          repeat (8)
          begin
            #62 ext_clk = 1'b0;
            #63 ext_clk = 1'b1;
          end
        end
      join_none
  endtask
  task automatic wait_end(input int lim);
    nrx = 0;
    tx_at = 0;
    k = 0;
    went = 1'b0;
    for (int i = 1; i < lim && k < 4; i++)
    begin
      @(negedge CLOCK);
      if (rx_req) nrx++;
      if (tx_req && tx_at == 0) tx_at = i;
      if (stat.busy) went = 1'b1;
      else if (went) k++;
    end
    @(negedge CLOCK);
  endtask
  task automatic rd();
    rx_rd = 1'b1;
    @(negedge CLOCK);
    rx_rd = 1'b0;
    @(negedge CLOCK);
  endtask
  initial
  begin
    #200000;
    fails++;
    test_done();
  end
  initial
  begin
    ctrl = '0;
    ctrl.tx_enable = 1'b1;
    ctrl.rx_enable = 1'b1;
    ctrl.hs_disable = 1'b1;
    div = 8'h03;
    tx_data = 8'h00;
    peer_tx = 8'h00;
    repeat (16) @(negedge CLOCK);
    chk({s_out, clk_o, clk_oe, stat.tx_buffer_empty, tx_req, rx_req}, 16'h3C);
    RST_N = 1'b1;
    foreach (rows[r])
    begin
      ctrl.clk_polarity = rows[r].pol;
      ctrl.msb_first = rows[r].msb;
      ctrl.tx_irq_on_done = rows[r].cause;
      div = rows[r].div;
      repeat (4) @(negedge CLOCK);
      send(rows[r].t, rows[r].p);
      wait_end(9000);
      chk(16'(k), 16'h4);
      chk(peer_rx, rows[r].t);
      chk(rx_data, rows[r].p);
      chk(per[15:0], 16'(20 * (rows[r].div + 1)));
      chk(16'(nrx), 16'h1);
      chk(tx_at > 8, rows[r].cause);
      rd();
    end
    ctrl.clk_polarity = 1'b0;
    ctrl.msb_first = 1'b0;
    div = 8'h03;
    repeat (4) @(negedge CLOCK);
    send(8'h11, 8'h5A);
    wait_end(9000);
    send(8'h22, 8'hC3);
    wait_end(9000);
    chk(16'(nrx), 16'h0);
    chk({stat.overrun, rx_data}, 16'h1C3);
    rd();
    ctrl.ext_clock = 1'b1;
    repeat (2) @(negedge CLOCK);
    chk(clk_oe, 1'b0);
    send(8'h96, 8'h69);
    wait_end(3000);
    chk({peer_rx, rx_data}, 16'h9669);
    rd();
    ctrl.ext_clock = 1'b0;
    ctrl.hs_disable = 1'b0;
    repeat (2) @(negedge CLOCK);
    send(8'h5A, 8'h00);
    wait_end(60);
    chk(went, 1'b0);
    hs_drv = 1'b0;
    wait_end(9000);
    chk(peer_rx, 8'h5A);
    rd();
    ctrl.hs_rts_select = 1'b1;
    repeat (2) @(negedge CLOCK);
    chk(hs_oe, 1'b1);
    ctrl.hs_disable = 1'b1;
    g_out = 1'b1;
    g_oe = 1'b1;
    repeat (3) @(negedge CLOCK);
    chk({hs_oe, hs_o, g_in}, 16'h7);
    ctrl.data_invert = 1'b1;
    send(8'h0F, 8'h33);
    wait_end(9000);
    chk({peer_rx, rx_data}, 16'hF0CC);
    rd();
    ctrl.data_invert = 1'b0;
    // a read alone must start the next byte, the old buffer byte going out again
    ctrl.cont_receive = 1'b1;
    peer_tx = 8'hE7;
    load = 1'b1;
    rd();
    load = 1'b0;
    wait_end(9000);
    chk({peer_rx, rx_data}, 16'hF0E7);
    chk(16'(nrx), 16'h1);
    ctrl.cont_receive = 1'b0;
    ctrl.dual_clk_enable = 1'b1;
    ctrl.alt_pin_select = 1'b1;
    ctrl.hs_disable = 1'b0;
    repeat (2) @(negedge CLOCK);
    chk({alt_oe, alt_o, clk_oe, hs_oe}, 16'hC);
    ctrl.ext_clock = 1'b1;
    repeat (2) @(negedge CLOCK);
    chk({alt_oe, clk_oe}, 16'h0);
    test_done();
  end
endmodule // css_channel_tb_top
